// file: inc/iebuf_defs.svh
// Register map, field positions and reset values of the iso endpoint buffer
`ifndef IEBUF_DEFS_SVH
`define IEBUF_DEFS_SVH
`define IEB_A_CTRL 8'h00
`define IEB_A_CFG 8'h04
`define IEB_A_OCNTX 8'h08
`define IEB_A_OCNTY 8'h0C
`define IEB_A_ICNTX 8'h10
`define IEB_A_ICNTY 8'h14
`define IEB_A_FRAME 8'h18
`define IEB_A_ISTAT 8'h1C
`define IEB_A_IEN 8'h20
`define IEB_A_ICLR 8'h24
`define IEB_A_BADDR 8'h28
`define IEB_A_BDATA 8'h2C
`define IEB_CTRL_OEN 0
`define IEB_CTRL_IEN 1
`define IEB_CTRL_ODMA 2
`define IEB_CTRL_IDMA 3
`define IEB_CTRL_OBPS 4
`define IEB_CTRL_IBPS 6
`define IEB_CTRL_OSZ 8
`define IEB_CTRL_ISZ 16
`define IEB_FLAG_BIT 7
`define IEB_CNT_RST 8'h80
`define IEB_OFS_W 6
`define IEB_RAM_AW 8
`endif

// file: inc/iebuf_mem_if.sv
// Two-port byte buffer memory connection
`timescale 1ns/10ps
`default_nettype none
`include "iebuf_defs.svh"
interface iebuf_mem_if;
  logic a_we;
  logic [`IEB_RAM_AW-1:0] a_addr;
  logic [7:0] a_wdata;
  logic [7:0] a_rdata;
  logic b_we;
  logic [`IEB_RAM_AW-1:0] b_addr;
  logic [7:0] b_wdata;
  logic [7:0] b_rdata;
  modport ram (input a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, output a_rdata, b_rdata);
  modport ctl (output a_we, a_addr, a_wdata, b_we, b_addr, b_wdata, input a_rdata, b_rdata);
endinterface
`default_nettype wire

// file: inc/iebuf_pkg.sv
// Types shared by the iso endpoint buffer modules
package iebuf_pkg;
  typedef logic [7:0] iebuf_byte_type;
  typedef enum logic [1:0] {IEB_IN_IDLE, IEB_IN_SEND, IEB_IN_DRAIN} iebuf_in_st_type;
endpackage

// file: logic/iebuf_ram.sv
// X/Y endpoint buffer memory, USB port A and DMA/firmware port B
`timescale 1ns/10ps
`default_nettype none
`include "iebuf_defs.svh"
module iebuf_ram
  import iebuf_pkg::*;
(
  input wire logic sys_clk_i,
  iebuf_mem_if.ram mem
);
  iebuf_byte_type store_r [0:(1<<`IEB_RAM_AW)-1];

  // DMA works on the half the USB side is not using; firmware can address either half, and on a same-address clash the port B write wins
  // One process owns the array, so both write ports live here
  always_ff @(posedge sys_clk_i) begin
    if (mem.a_we) begin
      store_r[mem.a_addr] <= mem.a_wdata;
    end
    if (mem.b_we) begin
      store_r[mem.b_addr] <= mem.b_wdata;
    end
    mem.a_rdata <= store_r[mem.a_addr];
    mem.b_rdata <= store_r[mem.b_addr];
  end
endmodule // iebuf_ram
`default_nettype wire

// file: logic/iebuf_top.sv
// Isochronous endpoint X/Y buffer handling with DMA, USB side and APB slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "iebuf_defs.svh"
// What this block does
// - Out packet stored, count updated, flag set
// - Count byte holds samples, not bytes
// - No endpoint interrupt for iso traffic
// - Out overflow sets overflow bit
// - DMA writes codec samples into buffer
// - Frame end: DMA commits count, clears flag
// - DMA in overflow sets overflow bit
// - In token sends packet when flag clear
// - In transaction done sets flag
// - Flag still set: send zero-length packet
// - Each iso endpoint has X and Y
// - DMA idle for firmware-serviced endpoints
module iebuf_top
  import iebuf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  output logic irq_o,
  input wire logic sof_i,
  input wire logic pseudo_frame_start_i,
  input wire logic [10:0] frame_i,
  input wire logic out_vld_i,
  input wire logic [7:0] out_byte_i,
  input wire logic out_end_i,
  input wire logic in_token_i,
  output logic in_vld_o,
  output logic [7:0] in_byte_o,
  output logic in_last_o,
  output logic in_zlp_o,
  input wire logic rx_vld_i,
  input wire logic [7:0] rx_byte_i,
  output logic tx_vld_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_rdy_i
);
  iebuf_mem_if mem ();
  iebuf_ram u_ram (.sys_clk_i(sys_clk_i), .mem(mem));

  logic [31:0] ctrl_r;
  logic [1:0] ovf_r;
  logic [10:0] frame_r;
  logic usb_buf_r;
  logic [3:0] int_stat_r, int_en_r;
  logic [7:0] fw_ptr_r;
  iebuf_byte_type cnt_r [0:3];
  logic [3:0] hw_ld;
  iebuf_byte_type hw_val [0:3];
  logic tick, out_en, in_en, out_dma, in_dma;
  logic [1:0] out_bps, in_bps;
  logic [7:0] out_sz, in_sz;

  assign tick = sof_i | pseudo_frame_start_i;
  assign out_en = ctrl_r[`IEB_CTRL_OEN];
  assign in_en = ctrl_r[`IEB_CTRL_IEN];
  assign out_dma = ctrl_r[`IEB_CTRL_ODMA];
  assign in_dma = ctrl_r[`IEB_CTRL_IDMA];
  assign out_bps = ctrl_r[`IEB_CTRL_OBPS+:2];
  assign in_bps = ctrl_r[`IEB_CTRL_IBPS+:2];
  assign out_sz = ctrl_r[`IEB_CTRL_OSZ+:8];
  assign in_sz = ctrl_r[`IEB_CTRL_ISZ+:8];

  // Bytes in a packet of c samples of (b+1) bytes each
  function automatic logic [8:0] to_bytes(input logic [6:0] c, input logic [1:0] b);
    logic [10:0] p;
    p = {4'h0, c} * ({9'h000, b} + 11'h001);
    return p[8:0];
  endfunction

  // Frame parity picks the half; a pseudo frame start just advances it
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      frame_r <= 11'h000;
      usb_buf_r <= 1'b0;
    end else if (sof_i) begin
      frame_r <= frame_i;
      usb_buf_r <= frame_i[0];
    end else if (pseudo_frame_start_i) begin
      frame_r <= frame_r + 11'h001;
      usb_buf_r <= ~usb_buf_r;
    end
  end

  // ---- USB side, out endpoint write ----
  logic [6:0] uo_ptr_r, uo_smp_r;
  logic [1:0] uo_sub_r;
  logic uo_full, uo_we;
  assign uo_full = uo_ptr_r[6] | ({1'b0, uo_ptr_r} >= out_sz);
  assign uo_we = out_vld_i & out_en & ~uo_full;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || tick || out_end_i) begin
      uo_ptr_r <= 7'h00;
      uo_smp_r <= 7'h00;
      uo_sub_r <= 2'h0;
    end else if (uo_we) begin
      uo_ptr_r <= uo_ptr_r + 7'h01;
      uo_sub_r <= (uo_sub_r == out_bps) ? 2'h0 : uo_sub_r + 2'h1;
      if (uo_sub_r == out_bps) begin
        uo_smp_r <= uo_smp_r + 7'h01;
      end
    end
  end

  // ---- USB side, in endpoint read ----
  iebuf_in_st_type ui_st_r;
  logic [8:0] ui_len_r, ui_ptr_r;
  logic ui_idx_r, ui_rd, ui_v1_r, ui_l1_r, ui_done, ui_zdone;
  logic [7:0] ui_cnt;
  assign ui_cnt = cnt_r[{1'b1, usb_buf_r}];
  assign ui_rd = (ui_st_r == IEB_IN_SEND) & ~out_vld_i;
  assign ui_done = in_vld_o & in_last_o;
  assign ui_zdone = (ui_st_r == IEB_IN_IDLE) & in_token_i & in_en & ~ui_cnt[`IEB_FLAG_BIT]
    & (to_bytes(ui_cnt[6:0], in_bps) == 9'h000);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ui_st_r <= IEB_IN_IDLE;
      ui_len_r <= 9'h000;
      ui_ptr_r <= 9'h000;
      ui_idx_r <= 1'b0;
      ui_v1_r <= 1'b0;
      ui_l1_r <= 1'b0;
      in_zlp_o <= 1'b0;
    end else begin
      in_zlp_o <= 1'b0;
      ui_v1_r <= ui_rd;
      ui_l1_r <= ui_rd & (ui_ptr_r == ui_len_r - 9'h001);
      case (ui_st_r)
        IEB_IN_IDLE: begin
          if (in_token_i && in_en) begin
            ui_idx_r <= usb_buf_r;
            ui_len_r <= to_bytes(ui_cnt[6:0], in_bps);
            ui_ptr_r <= 9'h000;
            if (ui_cnt[`IEB_FLAG_BIT] || ui_zdone) begin
              in_zlp_o <= 1'b1;
            end else begin
              ui_st_r <= IEB_IN_SEND;
            end
          end
        end
        IEB_IN_SEND: begin
          if (ui_rd) begin
            ui_ptr_r <= ui_ptr_r + 9'h001;
            if (ui_ptr_r == ui_len_r - 9'h001) begin
              ui_st_r <= IEB_IN_DRAIN;
            end
          end
        end
        IEB_IN_DRAIN: begin
          if (ui_done) begin
            ui_st_r <= IEB_IN_IDLE;
          end
        end
        default: ui_st_r <= IEB_IN_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      in_vld_o <= 1'b0;
      in_last_o <= 1'b0;
      in_byte_o <= 8'h00;
    end else begin
      in_vld_o <= ui_v1_r;
      in_last_o <= ui_l1_r;
      in_byte_o <= ui_v1_r ? mem.a_rdata : 8'h00;
    end
  end

  // Port A: out write beats in read, the in reader waits a cycle
  always_comb begin
    mem.a_we = uo_we;
    mem.a_wdata = out_byte_i;
    mem.a_addr = uo_we ? {1'b0, usb_buf_r, uo_ptr_r[5:0]}
                       : {1'b1, ui_idx_r, ui_ptr_r[5:0]};
  end

  // ---- DMA in: codec to the half the USB side is not using ----
  logic [6:0] di_ptr_r, di_smp_r;
  logic [1:0] di_sub_r;
  logic di_full, di_we;
  assign di_full = di_ptr_r[6] | ({1'b0, di_ptr_r} >= in_sz);
  assign di_we = rx_vld_i & in_dma & in_en & ~di_full;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || tick) begin
      di_ptr_r <= 7'h00;
      di_smp_r <= 7'h00;
      di_sub_r <= 2'h0;
    end else if (di_we) begin
      di_ptr_r <= di_ptr_r + 7'h01;
      di_sub_r <= (di_sub_r == in_bps) ? 2'h0 : di_sub_r + 2'h1;
      if (di_sub_r == in_bps) begin
        di_smp_r <= di_smp_r + 7'h01;
      end
    end
  end

  // ---- DMA out: drain the half the USB side filled last frame ----
  logic do_act_r, do_idx_r, do_pend_r, do_rd, do_st;
  logic [8:0] do_len_r, do_ptr_r;
  logic [7:0] do_cnt;
  assign do_cnt = cnt_r[{1'b0, ~usb_buf_r}];
  assign do_st = ~do_act_r & out_dma & out_en & do_cnt[`IEB_FLAG_BIT] & ~tick;
  assign do_rd = do_act_r & ~tx_vld_o & ~do_pend_r & ~di_we & (do_ptr_r < do_len_r);
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      do_act_r <= 1'b0;
      do_idx_r <= 1'b0;
      do_len_r <= 9'h000;
      do_ptr_r <= 9'h000;
      do_pend_r <= 1'b0;
    end else begin
      do_pend_r <= do_rd;
      if (do_st) begin
        do_act_r <= 1'b1;
        do_idx_r <= ~usb_buf_r;
        do_len_r <= to_bytes(do_cnt[6:0], out_bps);
        do_ptr_r <= 9'h000;
      end else if (tick || (do_act_r && do_ptr_r == do_len_r && !do_pend_r && !tx_vld_o)) begin
        do_act_r <= 1'b0; // A new frame ends any unfinished drain
      end else if (do_rd) begin
        do_ptr_r <= do_ptr_r + 9'h001;
      end
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tx_vld_o <= 1'b0;
      tx_byte_o <= 8'h00;
    end else if (do_pend_r) begin
      tx_vld_o <= 1'b1;
      tx_byte_o <= mem.b_rdata;
    end else if (tx_rdy_i) begin
      tx_vld_o <= 1'b0;
    end
  end

  // ---- APB slave ----
  logic acc, is_data, ap_go, ap_rd_r, wr_fire, unmapped;
  logic [31:0] rd_val;
  assign acc = psel_i & penable_i & ~pready_o;
  assign is_data = (paddr_i == `IEB_A_BDATA);
  assign ap_go = acc & is_data & ~ap_rd_r & ~di_we & ~do_rd;
  assign wr_fire = psel_i & penable_i & pwrite_i & pready_o;
  always_comb begin
    unmapped = 1'b0;
    rd_val = 32'h0000_0000;
    case (paddr_i)
      `IEB_A_CTRL: rd_val = ctrl_r;
      `IEB_A_CFG: rd_val = {23'h000000, usb_buf_r, 6'h00, ovf_r};
      `IEB_A_OCNTX: rd_val = {24'h000000, cnt_r[0]};
      `IEB_A_OCNTY: rd_val = {24'h000000, cnt_r[1]};
      `IEB_A_ICNTX: rd_val = {24'h000000, cnt_r[2]};
      `IEB_A_ICNTY: rd_val = {24'h000000, cnt_r[3]};
      `IEB_A_FRAME: rd_val = {21'h000000, frame_r};
      `IEB_A_ISTAT: rd_val = {28'h0000000, int_stat_r};
      `IEB_A_IEN: rd_val = {28'h0000000, int_en_r};
      `IEB_A_ICLR: rd_val = 32'h0000_0000;
      `IEB_A_BADDR: rd_val = {24'h000000, fw_ptr_r};
      `IEB_A_BDATA: rd_val = 32'h0000_0000;
      default: unmapped = 1'b1;
    endcase
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      ap_rd_r <= 1'b0;
    end else begin
      ap_rd_r <= ap_go & ~pwrite_i;
      pready_o <= acc & (~is_data | (ap_go & pwrite_i) | ap_rd_r);
      pslverr_o <= acc & unmapped;
      if (acc) begin
        prdata_o <= ap_rd_r ? {24'h000000, mem.b_rdata} : rd_val;
      end
    end
  end

  // Port B: codec byte first, then the drain read, then firmware
  always_comb begin
    mem.b_we = di_we | (~do_rd & ap_go & pwrite_i);
    mem.b_wdata = di_we ? rx_byte_i : pwdata_i[7:0];
    if (di_we) begin
      mem.b_addr = {1'b1, ~usb_buf_r, di_ptr_r[5:0]};
    end else if (do_rd) begin
      mem.b_addr = {1'b0, do_idx_r, do_ptr_r[5:0]};
    end else begin
      mem.b_addr = fw_ptr_r;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_r <= 32'h0000_0000;
      int_en_r <= 4'h0;
      fw_ptr_r <= 8'h00;
    end else begin
      if (wr_fire && paddr_i == `IEB_A_CTRL) ctrl_r <= pwdata_i;
      if (wr_fire && paddr_i == `IEB_A_IEN) int_en_r <= pwdata_i[3:0];
      if (wr_fire && paddr_i == `IEB_A_BADDR) begin
        fw_ptr_r <= pwdata_i[7:0];
      end else if (ap_go) begin
        fw_ptr_r <= fw_ptr_r + 8'h01;
      end
    end
  end

  // ---- Count bytes with not-ready flag, one per half ----
  genvar g;
  for (g = 0; g < 4; g++) begin : g_cnt
    localparam logic EP = (g >= 2);
    localparam logic HB = (g % 2) == 1;
    always_comb begin
      hw_ld[g] = 1'b0;
      hw_val[g] = cnt_r[g];
      if (!EP && out_end_i && out_en && !tick && usb_buf_r == HB) begin
        hw_ld[g] = 1'b1;
        hw_val[g] = {1'b1, uo_smp_r};
      end else if (EP && tick && in_dma && in_en && usb_buf_r != HB) begin
        hw_ld[g] = 1'b1;
        hw_val[g] = {1'b0, di_smp_r};
      end else if (EP && (ui_done || ui_zdone) && (ui_done ? ui_idx_r : usb_buf_r) == HB) begin
        hw_ld[g] = 1'b1;
        hw_val[g] = {1'b1, cnt_r[g][6:0]};
      end else if (!EP && do_st && usb_buf_r != HB) begin
        hw_ld[g] = 1'b1;
        hw_val[g] = {1'b0, cnt_r[g][6:0]};
      end
    end
    // Hardware updates win over a firmware write in the same cycle
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        cnt_r[g] <= `IEB_CNT_RST;
      end else if (hw_ld[g]) begin
        cnt_r[g] <= hw_val[g];
      end else if (wr_fire && paddr_i == `IEB_A_OCNTX + 8'(4 * g)) begin
        cnt_r[g] <= pwdata_i[7:0];
      end
    end
  end

  // ---- Overflow bits and interrupts ----
  logic uo_ovf, di_ovf;
  logic [3:0] ev, clr;
  assign uo_ovf = out_vld_i & out_en & uo_full & ~tick;
  assign di_ovf = rx_vld_i & in_dma & in_en & di_full & ~tick;
  // Only frame starts and overflows interrupt; packet traffic never does
  assign ev = {di_ovf, uo_ovf, pseudo_frame_start_i, sof_i};
  assign clr = (wr_fire && paddr_i == `IEB_A_ICLR) ? pwdata_i[3:0] : 4'h0;
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ovf_r <= 2'b00;
      int_stat_r <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      if (wr_fire && paddr_i == `IEB_A_CFG) begin
        ovf_r <= (ovf_r & ~pwdata_i[1:0]) | {di_ovf, uo_ovf};
      end else begin
        ovf_r <= ovf_r | {di_ovf, uo_ovf};
      end
      int_stat_r <= (int_stat_r & ~clr) | ev;
      irq_o <= |(int_stat_r & int_en_r);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  a_zlp_on_flag: assert property (in_token_i && in_en && ui_st_r == IEB_IN_IDLE
    && ui_cnt[`IEB_FLAG_BIT] |=> in_zlp_o) else $error("no zero-length packet");
  a_out_commit: assert property (out_end_i && out_en && !tick |=>
    cnt_r[{1'b0, usb_buf_r}][`IEB_FLAG_BIT]) else $error("out flag not set");
  a_out_samples: assert property (out_end_i && out_en && !tick |=>
    cnt_r[{1'b0, usb_buf_r}][6:0] == $past(uo_smp_r)) else $error("bad sample count");
  a_in_done: assert property (in_vld_o && in_last_o |=>
    cnt_r[{1'b1, ui_idx_r}][`IEB_FLAG_BIT]) else $error("in flag not set");
  a_dma_commit: assert property (tick && in_dma && in_en |=>
    !cnt_r[{1'b1, !$past(usb_buf_r)}][`IEB_FLAG_BIT]) else $error("flag not cleared");
  a_out_overflow: assert property (uo_ovf |=> ovf_r[0]) else $error("out overflow lost");
  a_in_overflow: assert property (di_ovf |=> ovf_r[1]) else $error("in overflow lost");
  a_mcu_no_dma: assert property (!out_dma && !do_act_r |=> !do_act_r ##1 !tx_vld_o)
    else $error("dma ran for firmware endpoint");
  a_buf_alt: assert property (sof_i |=> usb_buf_r == $past(frame_i[0]))
    else $error("buffer half wrong");
  c_zlp: cover property (in_zlp_o);
  c_in_pkt: cover property (in_vld_o && in_last_o);
  c_tx_beat: cover property (tx_vld_o && tx_rdy_i);
  c_ovf: cover property (ovf_r[0] && ovf_r[1]);
endmodule // iebuf_top
`default_nettype wire

// file: tb/iebuf_host_model.sv
// Host model: frame starts, iso out packets and in tokens with capture of the answer
`timescale 1ns/10ps
`default_nettype none
module iebuf_host_model (
  input wire logic clk_i,
  output logic sof_o,
  output logic pseudo_frame_start_o,
  output logic [10:0] frame_o,
  output logic out_vld_o,
  output logic [7:0] out_byte_o,
  output logic out_end_o,
  output logic in_token_o,
  input wire logic in_vld_i,
  input wire logic [7:0] in_byte_i,
  input wire logic in_last_i,
  input wire logic in_zlp_i
);
  logic [7:0] rxq [$];
  logic zlp_seen = 1'b0;
  logic last_seen = 1'b0;
  initial begin
    sof_o = 1'b0;
    pseudo_frame_start_o = 1'b0;
    frame_o = 11'h000;
    out_vld_o = 1'b0;
    out_byte_o = 8'h00;
    out_end_o = 1'b0;
    in_token_o = 1'b0;
  end
  // A pseudo start carries no frame number of its own
  task automatic frame_start(input logic pseudo, input logic [10:0] fn);
    @(posedge clk_i);
    sof_o <= ~pseudo;
    pseudo_frame_start_o <= pseudo;
    frame_o <= fn;
    @(posedge clk_i);
    sof_o <= 1'b0;
    pseudo_frame_start_o <= 1'b0;
  endtask
  task automatic send_out(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      out_vld_o <= 1'b1;
      out_byte_o <= base + 8'(i);
    end
    @(posedge clk_i);
    out_vld_o <= 1'b0;
    out_byte_o <= ~out_byte_o;  // Idle data never repeats the last valid byte
    out_end_o <= 1'b1;
    @(posedge clk_i);
    out_end_o <= 1'b0;
  endtask
  task automatic token();
    int n;
    n = 0;
    rxq.delete();
    zlp_seen = 1'b0;
    last_seen = 1'b0;
    @(posedge clk_i);
    in_token_o <= 1'b1;
    @(posedge clk_i);
    in_token_o <= 1'b0;
    while (n < 80 && !(zlp_seen || last_seen)) begin
      @(posedge clk_i);
      n++;
      if (in_vld_i === 1'b1) rxq.push_back(in_byte_i);
      if (in_vld_i === 1'b1 && in_last_i === 1'b1) last_seen = 1'b1;
      if (in_zlp_i === 1'b1) zlp_seen = 1'b1;
    end
    repeat (3) @(posedge clk_i);
  endtask
endmodule // iebuf_host_model
`default_nettype wire

// file: tb/iebuf_top_tb.sv
// Self-checking bench for the iso endpoint buffer block
`timescale 1ns/10ps
`default_nettype none
`include "iebuf_defs.svh"
module iebuf_top_tb;
  typedef struct {logic [1:0] bps; int n; logic [7:0] cnt;} iebuf_row_type;
  iebuf_row_type rows [5] = '{'{2'd0, 5, 8'h85}, '{2'd1, 6, 8'h83}, '{2'd3, 8, 8'h82},
    '{2'd1, 7, 8'h83}, '{2'd2, 9, 8'h83}};
  logic clk, srst, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic sof, pseudo_frame_start, out_vld, out_end, in_token, in_vld, in_last, in_zlp, rx_vld, tx_vld;
  logic [10:0] frame;
  logic [7:0] out_byte, in_byte, rx_byte, tx_byte;
  logic tx_rdy = 1'b0;
  logic [1:0] stall_cnt = 2'd0;
  logic [7:0] txq [$];
  int err_count = 0;
  int n_tests = 0;
  iebuf_top iebuf_top_i (.sys_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .irq_o(irq), .sof_i(sof), .pseudo_frame_start_i(pseudo_frame_start), .frame_i(frame),
    .out_vld_i(out_vld), .out_byte_i(out_byte), .out_end_i(out_end), .in_token_i(in_token),
    .in_vld_o(in_vld), .in_byte_o(in_byte), .in_last_o(in_last), .in_zlp_o(in_zlp),
    .rx_vld_i(rx_vld), .rx_byte_i(rx_byte), .tx_vld_o(tx_vld), .tx_byte_o(tx_byte),
    .tx_rdy_i(tx_rdy));
  iebuf_host_model host_i (.clk_i(clk), .sof_o(sof), .pseudo_frame_start_o(pseudo_frame_start), .frame_o(frame),
    .out_vld_o(out_vld), .out_byte_o(out_byte), .out_end_o(out_end), .in_token_o(in_token),
    .in_vld_i(in_vld), .in_byte_i(in_byte), .in_last_i(in_last), .in_zlp_i(in_zlp));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Codec sink stalls one cycle in four so the drain handshake is exercised
  always @(posedge clk) begin
    stall_cnt <= stall_cnt + 2'd1;
    tx_rdy <= (stall_cnt != 2'd3);
    if (tx_vld === 1'b1 && tx_rdy === 1'b1) txq.push_back(tx_byte);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, a > `IEB_A_BDATA});
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  task automatic send_rx(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_vld <= 1'b1;
      rx_byte <= base + 8'(i);
      @(posedge clk);
      rx_vld <= 1'b0;
      rx_byte <= ~rx_byte;
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_vld = 1'b0;
    rx_byte = 8'h00;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(`IEB_A_CTRL, 32'hFFFF_FFFF, 32'h0);
    for (int k = 0; k < 4; k++) rd(`IEB_A_OCNTX + 8'(4 * k), 32'hFF, 32'h80);
    rd(8'h30, 32'hFFFF_FFFF, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    wr(`IEB_A_OCNTX, 32'h0);
    wr(`IEB_A_OCNTY, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(`IEB_A_CTRL, 32'h0000_4001 | (32'(rows[i].bps) << 4));
      host_i.frame_start(1'b0, 11'(2 * i));
      host_i.send_out(rows[i].n, 8'h10 + 8'(16 * i));
      rd(`IEB_A_OCNTX, 32'hFF, {24'h0, rows[i].cnt});
      wr(`IEB_A_BADDR, 32'h00);
      rd(`IEB_A_BDATA, 32'hFF, 32'h10 + 32'(16 * i));
    end
    chk(32'(txq.size()), 32'h0);
    wr(`IEB_A_ICLR, 32'hF);
    wr(`IEB_A_IEN, 32'hC);
    host_i.send_out(3, 8'h50);
    rd(`IEB_A_ISTAT, 32'hF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`IEB_A_CTRL, 32'h0000_0401);
    host_i.send_out(6, 8'h60);
    rd(`IEB_A_CFG, 32'h1, 32'h1);
    rd(`IEB_A_ISTAT, 32'h4, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(`IEB_A_IEN, 32'h0);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(`IEB_A_IEN, 32'h4);
    wr(`IEB_A_ICLR, 32'h4);
    wr(`IEB_A_CFG, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(`IEB_A_CFG, 32'h1, 32'h0);
    rd(`IEB_A_ICLR, 32'hFFFF_FFFF, 32'h0);
    host_i.frame_start(1'b1, 11'h000);
    rd(`IEB_A_ISTAT, 32'h2, 32'h2);
    rd(`IEB_A_FRAME, 32'h7FF, 32'h9);
    host_i.frame_start(1'b0, 11'h00A);
    txq.delete();
    wr(`IEB_A_CTRL, 32'h0000_4005);
    host_i.send_out(2, 8'hA0);
    host_i.frame_start(1'b0, 11'h00B);
    repeat (30) @(posedge clk);
    chk(txq.size() == 2 ? {16'h0, txq[0], txq[1]} : 32'hFFFF_FFFF, 32'h0000_A0A1);
    rd(`IEB_A_OCNTX, 32'hFF, 32'h02);
    wr(`IEB_A_CTRL, 32'h0040_000A);
    host_i.frame_start(1'b0, 11'h00D);
    host_i.token();
    chk({31'h0, host_i.zlp_seen}, 32'h1);
    send_rx(3, 8'h30);
    host_i.frame_start(1'b1, 11'h000);
    rd(`IEB_A_ICNTX, 32'hFF, 32'h03);
    host_i.token();
    chk(host_i.rxq.size() == 3 ? {8'h0, host_i.rxq[0], host_i.rxq[1], host_i.rxq[2]} :
      32'hFFFF_FFFF, 32'h0030_3132);
    chk({31'h0, host_i.last_seen}, 32'h1);
    rd(`IEB_A_ICNTX, 32'hFF, 32'h83);
    host_i.token();
    chk({31'h0, host_i.zlp_seen}, 32'h1);
    wr(`IEB_A_CTRL, 32'h0040_0002);
    wr(`IEB_A_BADDR, 32'hC0);
    wr(`IEB_A_BDATA, 32'h77);
    wr(`IEB_A_BDATA, 32'h78);
    wr(`IEB_A_ICNTY, 32'h02);
    host_i.frame_start(1'b0, 11'h00F);
    host_i.token();
    chk(host_i.rxq.size() == 2 ? {16'h0, host_i.rxq[0], host_i.rxq[1]} : 32'hFFFF_FFFF,
      32'h0000_7778);
    wr(`IEB_A_CTRL, 32'h0002_000A);
    send_rx(3, 8'h40);
    rd(`IEB_A_CFG, 32'h2, 32'h2);
    // Mid-run reset: control, overflow, status and the in Y count byte must return to idle
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(`IEB_A_CTRL, 32'hFFFF_FFFF, 32'h0);
    rd(`IEB_A_CFG, 32'hFFFF_FFFF, 32'h0);
    rd(`IEB_A_ISTAT, 32'hF, 32'h0);
    rd(`IEB_A_ICNTY, 32'hFF, 32'h80);
    tally_and_finish();
  end
endmodule // iebuf_top_tb
`default_nettype wire
